// file: verilog/fcec_pkg.sv
package fcec_pkg;
    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;

    // ----------------------------------------------------------------
    // Command cycle addresses and codes
    // ----------------------------------------------------------------
    localparam logic [17:0] UNLOCK_ADDR_A = 18'h05555;
    localparam logic [17:0] UNLOCK_ADDR_B = 18'h02aaa;
    localparam logic [7:0]  CODE_UNLOCK_A = 8'haa;
    localparam logic [7:0]  CODE_UNLOCK_B = 8'h55;
    localparam logic [7:0]  CODE_PROGRAM  = 8'ha0;
    localparam logic [7:0]  CODE_SETUP    = 8'h80;
    localparam logic [7:0]  CODE_CHIP_ERS = 8'h10;
    localparam logic [7:0]  CODE_SECT_ERS = 8'h30;
    localparam logic [7:0]  CODE_LOCKOUT  = 8'h40;
    localparam logic [7:0]  ERASED_BYTE   = 8'hff;

    // ----------------------------------------------------------------
    // Data pin bit positions used for status polling
    // ----------------------------------------------------------------
    localparam int POLL_BIT   = 7;
    localparam int TOGGLE_BIT = 6;

    // ----------------------------------------------------------------
    // Bus timing, 100 MHz core clock
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS      = 20;
    localparam int STROBE_NS     = 50;
    localparam int HOLD_NS       = 20;
    localparam int READ_NS       = 50;
    localparam logic [3:0] SETUP_CYC  = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] HOLD_CYC   = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] READ_CYC   = 4'((READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] ONE_CYC    = 4'h1;

    // ----------------------------------------------------------------
    // Host operations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_LOCKOUT
    } fcec_op_e;
endpackage

// file: verilog/fcec_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
// Single bus cycle engine: one write strobe cycle or one read cycle
module fcec_bus_cycle
    import fcec_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // Cycle request
    input  wire logic              start,
    input  wire logic              isWrite,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata,
    // Flash pins
    output logic [ADDR_W-1:0]      addressLines,
    output logic                   chipSel_b,
    output logic                   outGate_b,
    output logic                   writeStrobe_b,
    output logic [DATA_W-1:0]      dataOut,
    output logic                   dataOe_b,
    input  wire logic [DATA_W-1:0] dataPins
);
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_READ} fcec_cyc_e;

    fcec_cyc_e         state, next_state;
    logic [3:0]        cnt, next_cnt;
    logic              next_done, next_cs, next_oe, next_we, next_doe;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_dout, next_rdata;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt - ONE_CYC;
        next_done  = 1'b0;
        next_cs    = chipSel_b;
        next_oe    = outGate_b;
        next_we    = writeStrobe_b;
        next_doe   = dataOe_b;
        next_addr  = addressLines;
        next_dout  = dataOut;
        next_rdata = rdata;
        unique case (state)
            S_IDLE:
            begin
                next_cnt = cnt;
                if (start)
                begin
                    next_addr = addr;
                    next_cs   = 1'b0;
                    next_oe   = isWrite;          // Gate stays high on writes
                    next_dout = wdata;
                    next_doe  = ~isWrite;
                    next_state = isWrite ? S_SETUP : S_READ;
                    next_cnt   = isWrite ? SETUP_CYC : READ_CYC;
                end
            end
            S_SETUP:
                if (cnt == ONE_CYC)
                begin
                    next_we    = 1'b0;            // Falling strobe latches address
                    next_state = S_STROBE;
                    next_cnt   = STROBE_CYC;
                end
            S_STROBE:
                if (cnt == ONE_CYC)
                begin
                    next_we    = 1'b1;            // Rising strobe latches data
                    next_state = S_HOLD;
                    next_cnt   = HOLD_CYC;
                end
            S_HOLD:
                if (cnt == ONE_CYC)
                begin
                    next_cs    = 1'b1;
                    next_doe   = 1'b1;
                    next_done  = 1'b1;
                    next_state = S_IDLE;
                end
            S_READ:
                if (cnt == ONE_CYC)
                begin
                    next_rdata = dataPins;
                    next_cs    = 1'b1;
                    next_oe    = 1'b1;
                    next_done  = 1'b1;
                    next_state = S_IDLE;
                end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state         <= S_IDLE;
            cnt           <= '0;
            done          <= 1'b0;
            chipSel_b     <= 1'b1;
            outGate_b     <= 1'b1;
            writeStrobe_b <= 1'b1;
            dataOe_b      <= 1'b1;
            addressLines  <= '0;
            dataOut       <= '0;
            rdata         <= '0;
        end
        else
        begin
            state         <= next_state;
            cnt           <= next_cnt;
            done          <= next_done;
            chipSel_b     <= next_cs;
            outGate_b     <= next_oe;
            writeStrobe_b <= next_we;
            dataOe_b      <= next_doe;
            addressLines  <= next_addr;
            dataOut       <= next_dout;
            rdata         <= next_rdata;
        end
    end
endmodule // fcec_bus_cycle
`default_nettype wire

// file: verilog/fcec_host.sv
// Functional notes
// - Host pulses strobe low, gate high.
// - Host reissues operation cut by reset; this host drops it and returns to idle.
// - Alternate main blocks between erases; this host erases whichever sector the request addresses.
// - Wait program end before next access.
// - Program: AA, 55, A0, address/data.
// - Six-cycle unlock, setup, then final code.
`timescale 1ns/1ps
`default_nettype none
module fcec_host
    import fcec_pkg::*;
#(
    parameter int POLL_LIMIT = 1200000000 // Chip erase limit in polls
)
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // Operation request
    input  wire logic              opStart,
    input  wire fcec_op_e          opCode,
    input  wire logic [ADDR_W-1:0] opAddr,
    input  wire logic [DATA_W-1:0] opData,
    output logic                   opBusy,
    output logic                   opDone,
    output logic                   opTimeout,
    output logic [DATA_W-1:0]      opRdata,
    // Flash pins
    output logic [ADDR_W-1:0]      addressLines,
    output logic                   chipSel_b,
    output logic                   outGate_b,
    output logic                   writeStrobe_b,
    output logic                   flashReset_b,
    output logic [DATA_W-1:0]      dataOut,
    output logic                   dataOe_b,
    input  wire logic [DATA_W-1:0] dataPins
);
    typedef enum logic [2:0] {H_IDLE, H_ISSUE, H_WAIT, H_POLL, H_FINISH} fcec_host_e;

    fcec_host_e        state, next_state;
    fcec_op_e          op, next_op;
    logic [2:0]        step, next_step;
    logic [ADDR_W-1:0] tgtAddr, next_tgtAddr;
    logic [DATA_W-1:0] tgtData, next_tgtData;
    logic [DATA_W-1:0] lastPoll, next_lastPoll;
    logic              havePoll, next_havePoll;
    logic [31:0]       polls, next_polls;
    logic              next_busy, next_done, next_timeout;
    logic [DATA_W-1:0] next_rdata;
    logic              cycStart, cycWrite, cycDone;
    logic [ADDR_W-1:0] cycAddr;
    logic [DATA_W-1:0] cycData, cycRdata;
    logic [2:0]        lastStep;

    // ----------------------------------------------------------------
    // Bus cycle engine
    // ----------------------------------------------------------------
    fcec_bus_cycle u_cycle (
        .core_clk      (core_clk),
        .rst_b         (rst_b),
        .start         (cycStart),
        .isWrite       (cycWrite),
        .addr          (cycAddr),
        .wdata         (cycData),
        .done          (cycDone),
        .rdata         (cycRdata),
        .addressLines  (addressLines),
        .chipSel_b     (chipSel_b),
        .outGate_b     (outGate_b),
        .writeStrobe_b (writeStrobe_b),
        .dataOut       (dataOut),
        .dataOe_b      (dataOe_b),
        .dataPins      (dataPins)
    );

    // ----------------------------------------------------------------
    // Command step table
    // ----------------------------------------------------------------
    always_comb
    begin
        lastStep = (op == OP_PROGRAM) ? 3'h3 : 3'h5;
        cycWrite = (op != OP_READ);
        cycAddr  = tgtAddr;
        cycData  = tgtData;
        unique case (step)
            3'h0, 3'h3:
            begin
                cycAddr = UNLOCK_ADDR_A;
                cycData = CODE_UNLOCK_A;
                if (op == OP_PROGRAM && step == 3'h3)
                begin
                    cycAddr = tgtAddr;                      // Target byte
                    cycData = tgtData;
                end
            end
            3'h1, 3'h4:
            begin
                cycAddr = UNLOCK_ADDR_B;
                cycData = CODE_UNLOCK_B;
            end
            3'h2:
            begin
                cycAddr = UNLOCK_ADDR_A;
                cycData = (op == OP_PROGRAM) ? CODE_PROGRAM : CODE_SETUP;
            end
            3'h5:
            begin
                cycAddr = UNLOCK_ADDR_A;
                unique case (op)
                    OP_CHIP_ERASE: cycData = CODE_CHIP_ERS;
                    OP_SECTOR_ERASE:
                    begin
                        cycAddr = tgtAddr;
                        cycData = CODE_SECT_ERS;
                    end
                    OP_LOCKOUT: cycData = CODE_LOCKOUT;
                    default: cycData = CODE_UNLOCK_A;
                endcase
            end
            default:
            begin
                cycAddr = tgtAddr;
                cycData = tgtData;
            end
        endcase
        if (state == H_POLL || op == OP_READ)
        begin
            cycWrite = 1'b0;
            cycAddr  = tgtAddr;                             // Plain reads and polls use target
        end
        cycStart = (state == H_ISSUE) || (state == H_POLL && !cycDone);
    end

    // ----------------------------------------------------------------
    // Operation sequencer next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state    = state;
        next_op       = op;
        next_step     = step;
        next_tgtAddr  = tgtAddr;
        next_tgtData  = tgtData;
        next_lastPoll = lastPoll;
        next_havePoll = havePoll;
        next_polls    = polls;
        next_busy     = opBusy;
        next_done     = 1'b0;
        next_timeout  = opTimeout;
        next_rdata    = opRdata;
        unique case (state)
            H_IDLE:
                if (opStart)
                begin
                    next_op      = opCode;
                    next_tgtAddr = opAddr;
                    next_tgtData = opData;
                    next_step    = '0;
                    next_busy    = 1'b1;
                    next_timeout = 1'b0;
                    next_state   = H_ISSUE;
                end
            H_ISSUE:
                next_state = H_WAIT;
            H_WAIT:
                if (cycDone)
                begin
                    if (op == OP_READ)
                    begin
                        next_rdata = cycRdata;
                        next_state = H_FINISH;
                    end
                    else if (step == lastStep)
                    begin
                        next_polls    = '0;
                        next_havePoll = 1'b0;
                        next_state    = H_POLL;              // Wait for end
                    end
                    else
                    begin
                        next_step  = step + 3'h1;
                        next_state = H_ISSUE;
                    end
                end
            H_POLL:
                if (cycDone)
                begin
                    next_polls    = polls + 32'h1;
                    next_lastPoll = cycRdata;
                    next_havePoll = 1'b0;
                    if (havePoll && cycRdata[TOGGLE_BIT] == lastPoll[TOGGLE_BIT])
                    begin
                        next_rdata = cycRdata;              // Toggle stopped
                        next_state = H_FINISH;
                    end
                    else if (polls == 32'(POLL_LIMIT))
                    begin
                        next_timeout = 1'b1;                // Past erase limit
                        next_state   = H_FINISH;
                    end
                    else
                        next_havePoll = 1'b1;
                end
                else if (havePoll)
                    next_havePoll = havePoll;
            H_FINISH:
            begin
                next_busy  = 1'b0;
                next_done  = 1'b1;
                next_state = H_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers; flash reset follows host reset
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state        <= H_IDLE;
            op           <= OP_READ;
            step         <= '0;
            tgtAddr      <= '0;
            tgtData      <= '0;
            lastPoll     <= '0;
            havePoll     <= 1'b0;
            polls        <= '0;
            opBusy       <= 1'b0;
            opDone       <= 1'b0;
            opTimeout    <= 1'b0;
            opRdata      <= '0;
            flashReset_b <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            op           <= next_op;
            step         <= next_step;
            tgtAddr      <= next_tgtAddr;
            tgtData      <= next_tgtData;
            lastPoll     <= next_lastPoll;
            havePoll     <= next_havePoll;
            polls        <= next_polls;
            opBusy       <= next_busy;
            opDone       <= next_done;
            opTimeout    <= next_timeout;
            opRdata      <= next_rdata;
            flashReset_b <= 1'b1;
        end
    end
endmodule // fcec_host
`default_nettype wire

// file: tb/fcec_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fcec_host_assertions
    import fcec_pkg::*;
#(
    parameter int POLL_LIMIT = 20
)
(
    // Clock, reset and handshake
    input wire logic              core_clk,
    input wire logic              rst_b,
    input wire logic              opStart,
    input wire logic              opBusy,
    input wire logic              opDone,
    // Flash pins
    input wire logic [ADDR_W-1:0] addressLines,
    input wire logic              chipSel_b,
    input wire logic              outGate_b,
    input wire logic              writeStrobe_b,
    input wire logic              flashReset_b,
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic              dataOe_b
);
    // ----------------------------------------
    // Pin protocol and handshake checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    a_reset_quiet:
        assert property (disable iff (1'b0) !rst_b |=> chipSel_b && writeStrobe_b && outGate_b
            && dataOe_b && !flashReset_b && !opBusy && !opDone) else $error("pins active in reset");
    a_release_pin:
        assert property (disable iff (1'b0) rst_b |=> flashReset_b) else $error("flash reset held");
    a_write_gate:
        assert property (!writeStrobe_b |-> outGate_b && !chipSel_b && !dataOe_b)
            else $error("strobe without select or with gate");
    a_no_contention:
        assert property (!outGate_b |-> dataOe_b && writeStrobe_b && !chipSel_b)
            else $error("read gate while host drives");
    a_write_stable:
        assert property (!$past(writeStrobe_b) |-> $stable(addressLines) && $stable(dataOut))
            else $error("address or data moved under strobe");
    a_strobe_width:
        assert property ($fell(writeStrobe_b) |-> !writeStrobe_b [*5] ##1 writeStrobe_b)
            else $error("strobe width wrong");
    a_select_hold:
        assert property ($rose(writeStrobe_b) |-> (!chipSel_b && !dataOe_b) [*2])
            else $error("select or data dropped early");
    a_read_width:
        assert property ($fell(outGate_b) |-> !outGate_b [*5] ##1 outGate_b)
            else $error("read gate width wrong");
    a_take_busy:
        assert property (opStart && !opBusy && !opDone |-> ##[1:2] opBusy)
            else $error("request not taken");
    a_done_pulse:
        assert property (opDone |=> !opDone) else $error("done longer than one cycle");

    // Main scenarios reached
    c_write: cover property ($fell(writeStrobe_b));
    c_read: cover property ($fell(outGate_b));
    c_done: cover property (opDone);
endmodule // fcec_host_assertions

bind fcec_host fcec_host_assertions #(.POLL_LIMIT(POLL_LIMIT)) chk_u (.core_clk, .rst_b,
    .opStart, .opBusy, .opDone, .addressLines, .chipSel_b, .outGate_b, .writeStrobe_b,
    .flashReset_b, .dataOut, .dataOe_b);
`default_nettype wire

// file: tb/fcec_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcec_flash_model
    import fcec_pkg::*;
(
    // Timer clock and erase speed
    input  wire logic              core_clk,
    input  wire logic              slow,
    // Flash pins
    input  wire logic [ADDR_W-1:0] addressLines,
    input  wire logic              chipSel_b,
    input  wire logic              outGate_b,
    input  wire logic              writeStrobe_b,
    input  wire logic              flashReset_b,
    input  wire logic [DATA_W-1:0] dataPins,
    output logic      [DATA_W-1:0] devData,
    output logic                   devOe_b
);
    // ----------------------------------------
    // Array, command walk and timer
    // ----------------------------------------
    logic [7:0]  mem [0:262143];
    logic [17:0] latA;
    logic [17:0] expA;
    logic [7:0]  expD;
    logic [7:0]  lastD = 8'h00;
    logic [2:0]  step = 3'h0;
    logic        arm = 1'b0;
    logic        lockEn = 1'b0;
    logic        tog = 1'b0;
    logic        ok;
    int          busy = 0;
    wire logic   wrLow = !chipSel_b && !writeStrobe_b && outGate_b;
    wire logic   rdLow = !chipSel_b && !outGate_b && writeStrobe_b && flashReset_b;

    // Power up erased, in read mode
    initial foreach (mem[i]) mem[i] = ERASED_BYTE;

    // Clear a range, sparing a locked boot block, and start the timer
    task automatic wipe(input int lo, input int hi);
        for (int i = lo; i <= hi; i++)
            if (!lockEn || i > 32'h3fff)
                mem[i] = ERASED_BYTE;
        lastD = 8'h00;
        busy = slow ? 400 : 60;
    endtask

    // Address taken on the later falling edge of select and strobe
    always @(posedge wrLow)
        latA = addressLines;

    // Data taken on the earlier rising edge; unlock and setup cycles never touch the array
    always @(negedge wrLow)
    begin
        ok = flashReset_b && busy == 0;
        expA = (step == 3'h1 || step == 3'h4) ? UNLOCK_ADDR_B : UNLOCK_ADDR_A;
        expD = (step == 3'h1 || step == 3'h4) ? CODE_UNLOCK_B : CODE_UNLOCK_A;
        if (step == 3'h2)
            expD = CODE_SETUP;
        if (ok && arm)
        begin
            if (!lockEn || latA > 18'h03fff)
                mem[latA] = mem[latA] & dataPins;
            lastD = dataPins;
            busy = 30;
            arm = 1'b0;
        end
        else if (ok && step == 3'h5 && dataPins == CODE_SECT_ERS)
        begin
            if (latA < 18'h04000) wipe(32'h0, 32'h3fff);
            else if (latA < 18'h06000) wipe(32'h4000, 32'h5fff);
            else if (latA < 18'h08000) wipe(32'h6000, 32'h7fff);
            else if (latA < 18'h20000) wipe(32'h8000, 32'h1ffff);
            else wipe(32'h20000, 32'h3ffff);
        end
        else if (ok && step == 3'h5 && latA == UNLOCK_ADDR_A && dataPins == CODE_CHIP_ERS)
            wipe(32'h0, 32'h3ffff);
        else if (ok && step == 3'h5 && latA == UNLOCK_ADDR_A && dataPins == CODE_LOCKOUT)
            lockEn = 1'b1;
        else if (ok && step == 3'h2 && latA == UNLOCK_ADDR_A && dataPins == CODE_PROGRAM)
            arm = 1'b1;
        step = (ok && latA == expA && dataPins == expD && step < 3'h5) ? step + 3'h1 : 3'h0;
    end

    // Internal timer; the reset pin halts any operation
    always @(posedge core_clk)
    begin
        if (!flashReset_b)
        begin
            busy = 0;
            arm = 1'b0;
        end
        else if (busy > 0)
            busy = busy - 1;
    end

    // Toggle bit flips on each read while busy
    always @(posedge rdLow)
        if (busy > 0)
            tog = ~tog;

    // Drive data only while selected and gated; status while busy
    always_comb
    begin
        devOe_b = !rdLow;
        devData = mem[addressLines];
        if (busy > 0)
            devData = {~lastD[7], tog, devData[5:0]};
    end
endmodule // fcec_flash_model
`default_nettype wire

// file: tb/flash_command_erase_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module flash_command_erase_control_test
    import fcec_pkg::*;
;
    typedef struct {logic [7:0] rd; logic tout; logic useRd;} fcec_exp_s;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic              core_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              opStart = 1'b0;
    logic              slow = 1'b0;
    fcec_op_e          opCode = OP_READ;
    logic [ADDR_W-1:0] opAddr = 18'h00000;
    logic [DATA_W-1:0] opData = 8'h00;
    logic [DATA_W-1:0] floatPat = 8'h5a;
    logic [ADDR_W-1:0] addressLines;
    logic [DATA_W-1:0] opRdata, dataOut, devData, dataPins;
    logic              opBusy, opDone, opTimeout, chipSel_b, outGate_b;
    logic              writeStrobe_b, flashReset_b, dataOe_b, devOe_b;
    logic [31:0]       rnd = 32'h7315f307;
    logic [17:0]       rA;
    logic [7:0]        rD;
    int                err_count = 0;
    int                compares = 0;
    fcec_exp_s         expQ[$];
    fcec_exp_s         cur;

    fcec_host #(.POLL_LIMIT(20)) dut_u (.core_clk, .rst_b, .opStart, .opCode, .opAddr, .opData,
        .opBusy, .opDone, .opTimeout, .opRdata, .addressLines, .chipSel_b, .outGate_b,
        .writeStrobe_b, .flashReset_b, .dataOut, .dataOe_b, .dataPins);
    fcec_flash_model flash_u (.core_clk, .slow, .addressLines, .chipSel_b, .outGate_b,
        .writeStrobe_b, .flashReset_b, .dataPins, .devData, .devOe_b);

    // Clock; the data wire is resolved from both drivers and wanders when released
    always #5 core_clk = ~core_clk;
    assign dataPins = !dataOe_b ? dataOut : (!devOe_b ? devData : floatPat);
    always @(posedge core_clk) floatPat <= ~floatPat;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want)
        begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Note the expectation, request at the falling edge, wait bounded for done
    task automatic runOp(input fcec_op_e op, input logic [17:0] a, input logic [7:0] d,
                         input logic [7:0] want, input logic useRd, input logic tout);
        int n;
        expQ.push_back('{want, tout, useRd});
        @(negedge core_clk);
        opCode = op;
        opAddr = a;
        opData = d;
        opStart = 1'b1;
        @(negedge core_clk);
        opStart = 1'b0;
        for (n = 0; n < 3000 && opDone !== 1'b1; n++)
            @(negedge core_clk);
        if (n == 3000)
        begin
            err_count++;
            print_verdict();
        end
        @(negedge core_clk);
    endtask

    // Score each finished operation against the oldest note
    always @(negedge core_clk)
    begin
        if (opDone === 1'b1)
        begin
            cur = expQ.pop_front();
            if (cur.useRd === 1'b1)
                check(opRdata, cur.rd);
            check({7'h00, opTimeout}, {7'h00, cur.tout});
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        rnd = lfsr(rnd);
        rA = {1'b1, rnd[16:0]};
        rD = rnd[31:24];
        // Erased read, program and read back, command addresses untouched
        runOp(OP_READ, rA, 8'h00, ERASED_BYTE, 1'b1, 1'b0);
        runOp(OP_PROGRAM, rA, rD, rD, 1'b1, 1'b0);
        runOp(OP_READ, rA, 8'h00, rD, 1'b1, 1'b0);
        runOp(OP_READ, UNLOCK_ADDR_A, 8'h00, ERASED_BYTE, 1'b1, 1'b0);
        runOp(OP_READ, UNLOCK_ADDR_B, 8'h00, ERASED_BYTE, 1'b1, 1'b0);
        // Sector erase clears one parameter block only
        runOp(OP_PROGRAM, 18'h04100, 8'h3c, 8'h3c, 1'b1, 1'b0);
        runOp(OP_PROGRAM, 18'h06100, 8'hc3, 8'hc3, 1'b1, 1'b0);
        runOp(OP_SECTOR_ERASE, 18'h04000, 8'h00, 8'h00, 1'b0, 1'b0);
        runOp(OP_READ, 18'h04100, 8'h00, ERASED_BYTE, 1'b1, 1'b0);
        runOp(OP_READ, 18'h06100, 8'h00, 8'hc3, 1'b1, 1'b0);
        // Locked boot byte survives program and chip erase
        runOp(OP_PROGRAM, 18'h00200, 8'h5a, 8'h5a, 1'b1, 1'b0);
        runOp(OP_LOCKOUT, 18'h00000, 8'h00, 8'h00, 1'b0, 1'b0);
        runOp(OP_PROGRAM, 18'h00200, 8'h00, 8'h5a, 1'b1, 1'b0);
        runOp(OP_CHIP_ERASE, 18'h00000, 8'h00, 8'h00, 1'b0, 1'b0);
        runOp(OP_READ, 18'h00200, 8'h00, 8'h5a, 1'b1, 1'b0);
        runOp(OP_READ, rA, 8'h00, ERASED_BYTE, 1'b1, 1'b0);
        // Slow erase runs out the poll limit; a reset then halts it
        slow = 1'b1;
        runOp(OP_CHIP_ERASE, 18'h00000, 8'h00, 8'h00, 1'b0, 1'b1);
        rst_b = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        runOp(OP_READ, 18'h00200, 8'h00, 8'h5a, 1'b1, 1'b0);
        print_verdict();
    end
endmodule // flash_command_erase_control_test
`default_nettype wire
